// file: logic/etdc_pkg.sv
// Shared constants and types for the EEPROM timebase divider controller
package etdc_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [15:0] ADDR_DIV_HIGH    = 16'hfe1a;
  localparam logic [15:0] ADDR_DIV_LOW     = 16'hfe1b;
  localparam logic [15:0] ADDR_DIV_HIGH_NV = 16'hfe10;
  localparam logic [15:0] ADDR_DIV_LOW_NV  = 16'hfe11;
  localparam logic [15:0] ADDR_CFG_NV      = 16'hfe1c;
  localparam logic [15:0] ADDR_CTRL        = 16'hfe12;

  // ----------------------------------------------------------------
  // Field positions and masks
  // ----------------------------------------------------------------
  localparam int          LOCK_DIS_BIT  = 7;
  localparam int          REF_SEL_BIT   = 0;
  localparam int          BUSY_BIT      = 4;
  localparam int          HALT_BIT      = 5;
  localparam int          SUSPECT_BIT   = 6;
  localparam logic [7:0]  DIV_HIGH_MASK = 8'h87;

  // ----------------------------------------------------------------
  // Values after reset and blank / factory contents
  // ----------------------------------------------------------------
  localparam logic [7:0]  NV_BLANK      = 8'hff;
  localparam logic [7:0]  CFG_FACTORY   = 8'hf0;
  localparam logic [7:0]  REG_RESET     = 8'h00;
  localparam logic [10:0] DIV_CNT_RESET = 11'h000;
  localparam logic [15:0] SEQ_CNT_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // Program / erase sequence states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ETDC_IDLE = 2'b00,
    ETDC_RUN  = 2'b01,
    ETDC_HALT = 2'b10
  } etdc_seq_t;

endpackage : etdc_pkg

// file: logic/etdc_top.sv
// Timebase divider, nonvolatile divisor copies and stop handling of the EEPROM controller
//
// Chosen here: strobed register access.
`timescale 1ns/1ps

module etdc_top #(
  parameter logic [15:0] SEQ_TICKS = 16'h0008
) (
  input  wire logic        CLK_IN,
  input  wire logic        ARST_N_IN,
  input  wire logic        CE_IN,
  input  wire logic [15:0] ADDR_IN,
  input  wire logic [7:0]  WDATA_IN,
  input  wire logic        WR_IN,
  input  wire logic        RD_IN,
  output logic      [7:0]  RDATA_OUT,
  input  wire logic        XTAL_REF_IN,
  input  wire logic        BUS_LATCH_IN,
  input  wire logic        PROGRAM_POWER_EN_IN,
  input  wire logic        ERASE_MODE_IN,
  input  wire logic        ARRAY_WRITE_VALID_IN,
  input  wire logic        STOP_IN,
  output logic             TICK_OUT,
  output logic             HV_ON_OUT,
  output logic             ACCESS_BLOCK_OUT,
  output logic             LOW_POWER_OUT,
  output logic      [7:0]  ARRAY_CFG_OUT
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [7:0]          div_high_ff;
  logic [7:0]          div_low_ff;
  // Copies have no reset: they start blank or as shipped and survive reset
  logic [7:0]          high_nv_ff = etdc_pkg::NV_BLANK;
  logic [7:0]          low_nv_ff  = etdc_pkg::NV_BLANK;
  logic [7:0]          cfg_nv_ff  = etdc_pkg::CFG_FACTORY;
  logic                load_pend_ff;
  logic                ref_sel_ff;
  logic                suspect_ff;
  logic                xtal_prev_ff;
  logic [10:0]         div_cnt_ff;
  logic                tick_ff;
  logic [15:0]         seq_cnt_ff;
  logic                lat_valid_ff;
  logic [15:0]         lat_addr_ff;
  logic [7:0]          lat_data_ff;
  logic [7:0]          rdata_ff;
  etdc_pkg::etdc_seq_t seq_ff;
  etdc_pkg::etdc_seq_t nxt_seq;

  logic [10:0] divisor;
  logic [10:0] div_m1;
  logic        lock_dis;
  logic        ref_evt;
  logic        tick_hit;
  logic        wr_ok;
  logic        wr_nv;
  logic        nv_is_div;
  logic        valid_any;
  logic        seq_done;
  logic        abort;

  // ----------------------------------------------------------------
  // Divisor view
  // ----------------------------------------------------------------
  // Top three divisor bits sit under the lock bit
  assign divisor  = {div_high_ff[2:0], div_low_ff};
  assign lock_dis = div_high_ff[etdc_pkg::LOCK_DIS_BIT];
  assign div_m1   = (divisor == 11'h000) ? 11'h000 : divisor - 11'h001;
  // Bus writes reach the live registers only when unlatched and unlocked
  assign wr_ok    = WR_IN && !BUS_LATCH_IN && lock_dis && !load_pend_ff;

  // ----------------------------------------------------------------
  // Live divider registers
  // ----------------------------------------------------------------
  // Reload from the copies on the first enabled edge after reset
  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      div_high_ff  <= etdc_pkg::REG_RESET;
      div_low_ff   <= etdc_pkg::REG_RESET;
      load_pend_ff <= 1'b1;
    end else if (CE_IN) begin
      if (load_pend_ff) begin
        div_high_ff  <= high_nv_ff & etdc_pkg::DIV_HIGH_MASK;
        div_low_ff   <= low_nv_ff;
        load_pend_ff <= 1'b0;
      end else if (wr_ok && ADDR_IN == etdc_pkg::ADDR_DIV_HIGH) begin
        div_high_ff <= WDATA_IN & etdc_pkg::DIV_HIGH_MASK;
      end else if (wr_ok && ADDR_IN == etdc_pkg::ADDR_DIV_LOW) begin
        div_low_ff <= WDATA_IN;
      end
    end
  end

  reset_load_a: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
    load_pend_ff && CE_IN |=> div_low_ff == $past(low_nv_ff)
      && div_high_ff == ($past(high_nv_ff) & etdc_pkg::DIV_HIGH_MASK))
    else $error("divisor not reloaded from copies");

  div_write_a: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
    CE_IN && WR_IN && ADDR_IN == etdc_pkg::ADDR_DIV_LOW && (BUS_LATCH_IN || !lock_dis)
      && !load_pend_ff |=> $stable(div_low_ff))
    else $error("blocked divisor write took effect");

  lock_forever_a: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
    !lock_dis && !load_pend_ff |=> !lock_dis)
    else $error("lock bit released without reset");

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  // Reference select; suspect flag set wins over its clear
  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      ref_sel_ff <= 1'b0;
      suspect_ff <= 1'b0;
    end else if (CE_IN) begin
      if (WR_IN && ADDR_IN == etdc_pkg::ADDR_CTRL) begin
        ref_sel_ff <= WDATA_IN[etdc_pkg::REF_SEL_BIT];
      end
      if (abort) begin
        suspect_ff <= 1'b1;
      end else if (WR_IN && ADDR_IN == etdc_pkg::ADDR_CTRL && WDATA_IN[etdc_pkg::SUSPECT_BIT]) begin
        suspect_ff <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Timebase counter
  // ----------------------------------------------------------------
  // Crystal input is synchronous, so a plain edge detect suffices
  assign ref_evt  = !STOP_IN && (ref_sel_ff ? (XTAL_REF_IN && !xtal_prev_ff) : 1'b1);
  // Compare with >= so a smaller divisor written mid-count still wraps
  assign tick_hit = ref_evt && (div_cnt_ff >= div_m1);

  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      xtal_prev_ff <= 1'b0;
      div_cnt_ff   <= etdc_pkg::DIV_CNT_RESET;
      tick_ff      <= 1'b0;
    end else if (CE_IN) begin
      xtal_prev_ff <= XTAL_REF_IN;
      tick_ff      <= tick_hit;
      if (tick_hit) begin
        div_cnt_ff <= etdc_pkg::DIV_CNT_RESET;
      end else if (ref_evt) begin
        div_cnt_ff <= div_cnt_ff + 11'h001;
      end
    end
  end

  tick_period_a: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
    CE_IN && ref_evt && div_cnt_ff == div_m1 |=> tick_ff && div_cnt_ff == 11'h000)
    else $error("timebase tick missing at terminal count");

  bus_ref_a: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
    CE_IN && !ref_sel_ff && !STOP_IN && div_cnt_ff < div_m1 |=> div_cnt_ff == $past(div_cnt_ff) + 11'h001)
    else $error("bus clock reference not counted");

  // ----------------------------------------------------------------
  // Bus capture for copy programming
  // ----------------------------------------------------------------
  assign nv_is_div = (ADDR_IN == etdc_pkg::ADDR_DIV_HIGH_NV) || (ADDR_IN == etdc_pkg::ADDR_DIV_LOW_NV);
  // Locked divider copies never become a valid target
  assign wr_nv     = WR_IN && BUS_LATCH_IN && seq_ff == etdc_pkg::ETDC_IDLE
                     && ((nv_is_div && lock_dis) || ADDR_IN == etdc_pkg::ADDR_CFG_NV);
  assign valid_any = lat_valid_ff || ARRAY_WRITE_VALID_IN;

  // Capture stays only while the latch bit holds the buses
  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      lat_valid_ff <= 1'b0;
      lat_addr_ff  <= 16'h0000;
      lat_data_ff  <= etdc_pkg::REG_RESET;
    end else if (CE_IN) begin
      if (!BUS_LATCH_IN || seq_done || abort) begin
        lat_valid_ff <= 1'b0;
      end else if (wr_nv) begin
        lat_valid_ff <= 1'b1;
        lat_addr_ff  <= ADDR_IN;
        lat_data_ff  <= WDATA_IN;
      end
    end
  end

  nv_lock_a: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
    CE_IN && !lock_dis && WR_IN && BUS_LATCH_IN && nv_is_div && !lat_valid_ff |=> !lat_valid_ff)
    else $error("locked divider copy was captured");

  // ----------------------------------------------------------------
  // Program / erase sequence
  // ----------------------------------------------------------------
  // Only stop gates the sequence; wait mode has no input here on purpose
  always_comb begin
    nxt_seq  = seq_ff;
    seq_done = 1'b0;
    abort    = 1'b0;
    unique case (seq_ff)
      etdc_pkg::ETDC_IDLE: begin
        if (PROGRAM_POWER_EN_IN && BUS_LATCH_IN && valid_any && !STOP_IN) begin
          nxt_seq = etdc_pkg::ETDC_RUN;
        end
      end
      etdc_pkg::ETDC_RUN: begin
        if (STOP_IN && BUS_LATCH_IN && PROGRAM_POWER_EN_IN) begin
          nxt_seq = etdc_pkg::ETDC_HALT;
        end else if (STOP_IN) begin
          nxt_seq = etdc_pkg::ETDC_IDLE;
          abort   = 1'b1;
        end else if (!PROGRAM_POWER_EN_IN) begin
          nxt_seq = etdc_pkg::ETDC_IDLE;
        end else if (tick_ff && seq_cnt_ff >= SEQ_TICKS - 16'h0001) begin
          nxt_seq  = etdc_pkg::ETDC_IDLE;
          seq_done = 1'b1;
        end
      end
      etdc_pkg::ETDC_HALT: begin
        if (!STOP_IN) begin
          nxt_seq = etdc_pkg::ETDC_RUN;
        end
      end
      default: nxt_seq = etdc_pkg::ETDC_IDLE; // Unused code recovers to idle
    endcase
  end

  // Sequence state and tick count; a restart begins from zero
  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      seq_ff     <= etdc_pkg::ETDC_IDLE;
      seq_cnt_ff <= etdc_pkg::SEQ_CNT_RESET;
    end else if (CE_IN) begin
      seq_ff <= nxt_seq;
      if (nxt_seq != etdc_pkg::ETDC_RUN || seq_ff != etdc_pkg::ETDC_RUN) begin
        seq_cnt_ff <= etdc_pkg::SEQ_CNT_RESET;
      end else if (tick_ff) begin
        seq_cnt_ff <= seq_cnt_ff + 16'h0001;
      end
    end
  end

  stop_halt_a: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
    CE_IN && seq_ff == etdc_pkg::ETDC_RUN && STOP_IN && BUS_LATCH_IN && PROGRAM_POWER_EN_IN
      |=> seq_ff == etdc_pkg::ETDC_HALT && ACCESS_BLOCK_OUT && !HV_ON_OUT)
    else $error("stop while latched did not halt");

  restart_a: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
    CE_IN && seq_ff == etdc_pkg::ETDC_HALT && !STOP_IN |=> seq_ff == etdc_pkg::ETDC_RUN && seq_cnt_ff == 16'h0000)
    else $error("halted sequence did not restart from zero");

  stop_abort_a: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
    CE_IN && seq_ff == etdc_pkg::ETDC_RUN && STOP_IN && !(BUS_LATCH_IN && PROGRAM_POWER_EN_IN)
      |=> seq_ff == etdc_pkg::ETDC_IDLE && suspect_ff)
    else $error("stop while unlatched did not abort");

  hv_cause_a: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
    $rose(HV_ON_OUT) |-> $past(valid_any) && BUS_LATCH_IN)
    else $error("high voltage without latch and valid write");

  // ----------------------------------------------------------------
  // Nonvolatile copies
  // ----------------------------------------------------------------
  // Program clears bits, erase sets the byte, as for array bytes
  always_ff @(posedge CLK_IN) begin
    if (CE_IN && seq_done && lat_valid_ff) begin
      if (lat_addr_ff == etdc_pkg::ADDR_DIV_HIGH_NV && lock_dis) begin
        high_nv_ff <= ERASE_MODE_IN ? etdc_pkg::NV_BLANK : (high_nv_ff & lat_data_ff);
      end
      if (lat_addr_ff == etdc_pkg::ADDR_DIV_LOW_NV && lock_dis) begin
        low_nv_ff <= ERASE_MODE_IN ? etdc_pkg::NV_BLANK : (low_nv_ff & lat_data_ff);
      end
      if (lat_addr_ff == etdc_pkg::ADDR_CFG_NV) begin
        cfg_nv_ff <= ERASE_MODE_IN ? etdc_pkg::NV_BLANK : (cfg_nv_ff & lat_data_ff);
      end
    end
  end

  nv_keep_a: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
    !(seq_done && CE_IN) |=> $stable(low_nv_ff) && $stable(high_nv_ff))
    else $error("copy changed outside a finished sequence");

  // ----------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------
  // Data stand one cycle after the strobe; unmapped reads zero
  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      rdata_ff <= etdc_pkg::REG_RESET;
    end else if (CE_IN) begin
      rdata_ff <= etdc_pkg::REG_RESET;
      if (RD_IN) begin
        unique case (ADDR_IN)
          etdc_pkg::ADDR_DIV_HIGH:    rdata_ff <= div_high_ff;
          etdc_pkg::ADDR_DIV_LOW:     rdata_ff <= div_low_ff;
          etdc_pkg::ADDR_DIV_HIGH_NV: rdata_ff <= high_nv_ff;
          etdc_pkg::ADDR_DIV_LOW_NV:  rdata_ff <= low_nv_ff;
          etdc_pkg::ADDR_CFG_NV:      rdata_ff <= cfg_nv_ff;
          etdc_pkg::ADDR_CTRL: begin
            rdata_ff[etdc_pkg::REF_SEL_BIT] <= ref_sel_ff;
            rdata_ff[etdc_pkg::BUSY_BIT]    <= seq_ff != etdc_pkg::ETDC_IDLE;
            rdata_ff[etdc_pkg::HALT_BIT]    <= seq_ff == etdc_pkg::ETDC_HALT;
            rdata_ff[etdc_pkg::SUSPECT_BIT] <= suspect_ff;
          end
          default:                    rdata_ff <= etdc_pkg::REG_RESET;
        endcase
      end
    end
  end

  rdata_idle_a: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
    CE_IN && !RD_IN |=> RDATA_OUT == etdc_pkg::REG_RESET)
    else $error("read data stood past its cycle");

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // High voltage dropped at once in stop, not a cycle later
  assign HV_ON_OUT        = seq_ff == etdc_pkg::ETDC_RUN && !STOP_IN;
  assign ACCESS_BLOCK_OUT = seq_ff != etdc_pkg::ETDC_IDLE;
  assign LOW_POWER_OUT    = STOP_IN;
  assign TICK_OUT         = tick_ff;
  assign RDATA_OUT        = rdata_ff;
  assign ARRAY_CFG_OUT    = cfg_nv_ff;

endmodule : etdc_top

// file: tb/etdc_top_test.sv
// Self-checking bench for the EEPROM timebase divider controller
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin checks++; if ((gt) !== (ex)) begin miscompares++; $display("BAD %s exp %h got %h", nm, ex, gt); end end
module etdc_top_test;
  // ----------------------------------------------------------------
  // Stimulus and observation signals
  // ----------------------------------------------------------------
  logic        clk    = 1'b0;
  logic        arst_n = 1'b0;
  logic        ce     = 1'b1;
  logic [15:0] addr   = 16'h0000;
  logic [7:0]  wdata  = 8'h00;
  logic        wr     = 1'b0;
  logic        rd     = 1'b0;
  logic        xtal   = 1'b0;
  logic        latch  = 1'b0;
  logic        pgm    = 1'b0;
  logic        erase  = 1'b0;
  logic        wvalid = 1'b0;
  logic        stop   = 1'b0;
  logic [7:0]  rdata;
  logic        tick;
  logic        hv;
  logic        blk;
  logic        lp;
  logic [7:0]  cfg;
  int          checks      = 0;
  int          miscompares = 0;
  logic [31:0] rnd         = 32'h0000ddb6;
  logic [7:0]  lo_nv       = 8'hff;
  logic [10:0] dv;
  logic        ok;
  int          k;

  // Short sequence length keeps each program cycle to a few ticks
  etdc_top #(.SEQ_TICKS(16'h0002)) i_etdc_top (
    .CLK_IN               (clk),
    .ARST_N_IN            (arst_n),
    .CE_IN                (ce),
    .ADDR_IN              (addr),
    .WDATA_IN             (wdata),
    .WR_IN                (wr),
    .RD_IN                (rd),
    .RDATA_OUT            (rdata),
    .XTAL_REF_IN          (xtal),
    .BUS_LATCH_IN         (latch),
    .PROGRAM_POWER_EN_IN  (pgm),
    .ERASE_MODE_IN        (erase),
    .ARRAY_WRITE_VALID_IN (wvalid),
    .STOP_IN              (stop),
    .TICK_OUT             (tick),
    .HV_ON_OUT            (hv),
    .ACCESS_BLOCK_OUT     (blk),
    .LOW_POWER_OUT        (lp),
    .ARRAY_CFG_OUT        (cfg)
  );

  // ----------------------------------------------------------------
  // Clocks: system clock and a crystal reference at half its rate
  // ----------------------------------------------------------------
  always #5 clk = ~clk;
  always @(posedge clk) xtal <= ~xtal;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    v = v ^ (v << 5);
    return v;
  endfunction : xs

  // High register keeps only the lock bit and the top three divisor bits
  function automatic logic [7:0] hi_exp(input logic [7:0] d);
    return d & 8'h87;
  endfunction : hi_exp

  task automatic stop_test();
    if (miscompares == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test

  task automatic do_reset();
    @(posedge clk);
    arst_n <= 1'b0;
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge clk);
  endtask : do_reset

  // Each access waits an edge first so back-to-back calls never collide
  task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic chk_reg(input logic [15:0] a, input logic [7:0] e, input logic [7:0] m);
    logic [7:0] d;
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
    `CHK("reg_read", e & m, d & m)
  endtask : chk_reg

  task automatic wait_hv(input logic lvl, input int lim, output logic seen);
    int n;
    n = 0;
    while (hv !== lvl && n < lim) begin
      @(posedge clk);
      #1 n++;
    end
    seen = (hv === lvl);
  endtask : wait_hv

  // Spacing in clocks between two later ticks; the first one only syncs
  task automatic tick_gap(output int g);
    repeat (2) begin
      g = 0;
      do begin
        @(posedge clk);
        #1 g++;
      end while (tick !== 1'b1 && g < 5000);
    end
  endtask : tick_gap

  task automatic finish_seq();
    logic s;
    wait_hv(1'b0, 9000, s);
    `CHK("hv_end", 1'b1, s)
    @(posedge clk);
    pgm <= 1'b0;
    @(posedge clk);
    latch <= 1'b0;
    #1;
  endtask : finish_seq

  // Program power is raised one edge after the latched write, as software would
  task automatic prog(input logic [15:0] a, input logic [7:0] d, input logic er, input logic go, input logic hold);
    logic s;
    latch <= 1'b1;
    erase <= er;
    wr_reg(a, d);
    @(posedge clk);
    pgm <= 1'b1;
    #1 wait_hv(1'b1, 4, s);
    `CHK("hv_start", go, s)
    `CHK("blocked", go, blk)
    if (!hold) finish_seq();
  endtask : prog

  // ----------------------------------------------------------------
  // Watchdog: far beyond the expected run of some 16k cycles
  // ----------------------------------------------------------------
  initial begin
    #600000;
    miscompares++;
    stop_test();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    do_reset();
    chk_reg(etdc_pkg::ADDR_DIV_HIGH, 8'h87, 8'hff);
    chk_reg(etdc_pkg::ADDR_DIV_LOW, 8'hff, 8'hff);
    chk_reg(etdc_pkg::ADDR_DIV_LOW_NV, 8'hff, 8'hff);
    chk_reg(etdc_pkg::ADDR_DIV_HIGH_NV, 8'hff, 8'hff);
    chk_reg(etdc_pkg::ADDR_CFG_NV, 8'hf0, 8'hff);
    chk_reg(etdc_pkg::ADDR_CTRL, 8'h00, 8'hff);
    `CHK("array_cfg", 8'hf0, cfg)
    // A frozen clock enable must swallow the write
    ce <= 1'b0;
    wr_reg(etdc_pkg::ADDR_DIV_LOW, 8'h5a);
    ce <= 1'b1;
    chk_reg(etdc_pkg::ADDR_DIV_LOW, 8'hff, 8'hff);
    // Random divisor values; a latched bus must refuse the write
    for (int i = 0; i < 6; i++) begin
      rnd = xs(rnd);
      wr_reg(etdc_pkg::ADDR_DIV_HIGH, rnd[7:0] | 8'h80);
      wr_reg(etdc_pkg::ADDR_DIV_LOW, rnd[15:8]);
      chk_reg(etdc_pkg::ADDR_DIV_HIGH, hi_exp(rnd[7:0] | 8'h80), 8'hff);
      latch <= 1'b1;
      wr_reg(etdc_pkg::ADDR_DIV_LOW, rnd[23:16]);
      latch <= 1'b0;
      chk_reg(etdc_pkg::ADDR_DIV_LOW, rnd[15:8], 8'hff);
    end
    // Tick spacing for smallest, largest and a random divisor on both references
    for (int j = 0; j < 3; j++) begin
      rnd = xs(rnd);
      dv = (j == 0) ? 11'h001 : (j == 1) ? 11'h7ff : 11'h002 + 11'(rnd[4:0]);
      wr_reg(etdc_pkg::ADDR_DIV_HIGH, {5'h10, dv[10:8]});
      wr_reg(etdc_pkg::ADDR_DIV_LOW, dv[7:0]);
      wr_reg(etdc_pkg::ADDR_CTRL, 8'h00);
      tick_gap(k);
      `CHK("bus_gap", int'(dv), k)
      wr_reg(etdc_pkg::ADDR_CTRL, 8'h01);
      tick_gap(k);
      `CHK("xtal_gap", 2 * int'(dv), k)
    end
    wr_reg(etdc_pkg::ADDR_CTRL, 8'h00);
    wr_reg(etdc_pkg::ADDR_DIV_HIGH, 8'h80);
    wr_reg(etdc_pkg::ADDR_DIV_LOW, 8'h04);
    // Program, then erase the low copy
    rnd = xs(rnd);
    prog(etdc_pkg::ADDR_DIV_LOW_NV, rnd[7:0], 1'b0, 1'b1, 1'b0);
    chk_reg(etdc_pkg::ADDR_DIV_LOW_NV, rnd[7:0], 8'hff);
    prog(etdc_pkg::ADDR_DIV_LOW_NV, 8'h00, 1'b1, 1'b1, 1'b0);
    chk_reg(etdc_pkg::ADDR_DIV_LOW_NV, 8'hff, 8'hff);
    // Power without latch stays off; an array write alone may start it
    pgm <= 1'b1;
    repeat (4) @(posedge clk);
    #1 `CHK("hv_unlatched", 1'b0, hv)
    latch  <= 1'b1;
    wvalid <= 1'b1;
    wait_hv(1'b1, 4, ok);
    `CHK("hv_array", 1'b1, ok)
    wvalid <= 1'b0;
    finish_seq();
    // Stop while latched and powered: halt, then restart on exit
    rnd = xs(rnd);
    prog(etdc_pkg::ADDR_DIV_LOW_NV, rnd[7:0], 1'b0, 1'b1, 1'b1);
    lo_nv = lo_nv & rnd[7:0];
    stop <= 1'b1;
    @(posedge clk);
    #1 `CHK("hv_halt", 1'b0, hv)
    `CHK("low_power", 1'b1, lp)
    chk_reg(etdc_pkg::ADDR_CTRL, 8'h20, 8'h20);
    repeat (30) @(posedge clk);
    #1 `CHK("halt_block", 1'b1, blk)
    stop <= 1'b0;
    wait_hv(1'b1, 4, ok);
    `CHK("hv_restart", 1'b1, ok)
    finish_seq();
    chk_reg(etdc_pkg::ADDR_DIV_LOW_NV, lo_nv, 8'hff);
    // Stop with the latch dropped aborts and flags suspect data
    prog(etdc_pkg::ADDR_DIV_LOW_NV, 8'h00, 1'b0, 1'b1, 1'b1);
    stop  <= 1'b1;
    latch <= 1'b0;
    repeat (3) @(posedge clk);
    #1 `CHK("abort_idle", 1'b0, blk)
    stop <= 1'b0;
    pgm  <= 1'b0;
    chk_reg(etdc_pkg::ADDR_CTRL, 8'h40, 8'hff);
    chk_reg(etdc_pkg::ADDR_DIV_LOW_NV, lo_nv, 8'hff);
    wr_reg(etdc_pkg::ADDR_CTRL, 8'h40);
    chk_reg(etdc_pkg::ADDR_CTRL, 8'h00, 8'hff);
    // Clearing the live lock bit freezes divider and divider copies until reset
    wr_reg(etdc_pkg::ADDR_DIV_HIGH, 8'h05);
    wr_reg(etdc_pkg::ADDR_DIV_LOW, 8'haa);
    wr_reg(etdc_pkg::ADDR_DIV_HIGH, 8'h87);
    chk_reg(etdc_pkg::ADDR_DIV_HIGH, 8'h05, 8'hff);
    chk_reg(etdc_pkg::ADDR_DIV_LOW, 8'h04, 8'hff);
    prog(etdc_pkg::ADDR_DIV_LOW_NV, 8'h00, 1'b0, 1'b0, 1'b0);
    chk_reg(etdc_pkg::ADDR_DIV_LOW_NV, lo_nv, 8'hff);
    do_reset();
    chk_reg(etdc_pkg::ADDR_DIV_HIGH, 8'h87, 8'hff);
    chk_reg(etdc_pkg::ADDR_DIV_LOW, lo_nv, 8'hff);
    // Lock the high copy for good; reset must bring the lock back
    wr_reg(etdc_pkg::ADDR_DIV_HIGH, 8'h80);
    wr_reg(etdc_pkg::ADDR_DIV_LOW, 8'h04);
    prog(etdc_pkg::ADDR_DIV_HIGH_NV, 8'h05, 1'b0, 1'b1, 1'b0);
    do_reset();
    chk_reg(etdc_pkg::ADDR_DIV_HIGH, 8'h05, 8'hff);
    wr_reg(etdc_pkg::ADDR_DIV_HIGH, 8'h87);
    chk_reg(etdc_pkg::ADDR_DIV_HIGH, 8'h05, 8'hff);
    prog(etdc_pkg::ADDR_DIV_HIGH_NV, 8'h00, 1'b1, 1'b0, 1'b0);
    chk_reg(etdc_pkg::ADDR_DIV_HIGH_NV, 8'h05, 8'hff);
    // The array config copy stays programmable under the divider lock
    prog(etdc_pkg::ADDR_CFG_NV, 8'h3c, 1'b0, 1'b1, 1'b0);
    chk_reg(etdc_pkg::ADDR_CFG_NV, 8'h30, 8'hff);
    `CHK("array_cfg", 8'h30, cfg)
    stop_test();
  end
endmodule : etdc_top_test
